// File: shared/anp_pkg.sv
/*
  anp_pkg: constants and types for the partner next page status register.
  assumes: included before any design file that imports it.
*/
`default_nettype none
package anp_pkg;
  // register map (decode width in bits, then byte addresses)
  localparam logic [3:0]  ANP_ADDR_W        = 4'h4;
  localparam logic [15:0] ANP_OFF_PAGE_WORD = 16'h0008;
  localparam logic [15:0] ANP_OFF_PAGE_CNT  = 16'h000C;
  // field positions within the page word
  localparam int ANP_BIT_MORE   = 15;
  localparam int ANP_BIT_ACK    = 14;
  localparam int ANP_BIT_FMT    = 13;
  localparam int ANP_BIT_COMPLY = 12;
  localparam int ANP_BIT_TOGGLE = 11;
  // reset values
  localparam logic [10:0] ANP_CODE_NULL = 11'h001;
  localparam logic [15:0] ANP_WORD_RST  = 16'h2001;
  // axi responses
  localparam logic [1:0]  ANP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  ANP_RESP_SLVERR = 2'h2;
  localparam logic [1:0]  ANP_RESP_DECERR = 2'h3;

  // decoded next page word
  typedef struct packed {
    logic        more_pages_flag;
    logic        ack;
    logic        formatted_page_flag;
    logic        can_comply_flag;
    logic        toggle;
    logic [10:0] code;
  } anp_page_s;
endpackage : anp_pkg
`default_nettype wire

// File: rtl/anp_partner_page.sv
/*
  anp_partner_page: read-only partner next page status register on an
  axi4-lite slave. assumes the arbitration logic presents each received
  page as a one-cycle strobe with the raw 16-bit word, synchronous to clock.
*/
// Our own choice: the AXI4-Lite register port.
// Function
// - bit 15 set means partner has further next pages to send.
// - bit 14 reads 1 when partner acknowledged the ability word.
// - acknowledge bit comes only from received bursts, never software.
// - bit 13 resets to 1; marks formatted message versus unformatted page.
// - bit 12 reads 1 when partner can comply with the message.
// - bit 11 holds inverse of toggle of previously exchanged code word.
// - code field resets to 001, the null message page.
`default_nettype none
module anp_partner_page
  import anp_pkg::*;
(
  input  wire logic        clock,          // 200 MHz core clock
  input  wire logic        rst_b,          // async reset, active low
  input  wire logic        page_rx_valid,  // one-cycle strobe, page received
  input  wire logic [15:0] page_rx_word,   // raw received page word
  input  wire logic        awvalid,        // write address valid
  output logic             awready,        // write address ready
  input  wire logic [31:0] awaddr,         // write address
  input  wire logic        wvalid,         // write data valid
  output logic             wready,         // write data ready
  input  wire logic [31:0] wdata,          // write data (ignored)
  input  wire logic [3:0]  wstrb,          // write strobes (ignored)
  output logic             bvalid,         // write response valid
  input  wire logic        bready,         // write response ready
  output logic [1:0]       bresp,          // write response
  input  wire logic        arvalid,        // read address valid
  output logic             arready,        // read address ready
  input  wire logic [31:0] araddr,         // read address
  output logic             rvalid,         // read data valid
  input  wire logic        rready,         // read data ready
  output logic [31:0]      rdata,          // read data
  output logic [1:0]       rresp,          // read response
  output logic [15:0]      page_word       // current page word, from register
);

  anp_page_s   page_reg;
  logic [15:0] cnt_reg;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [31:0] aw_addr_reg;

  // map an address to a known register
  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a[ANP_ADDR_W-1:0] == ANP_OFF_PAGE_WORD[ANP_ADDR_W-1:0]) ||
               (a[ANP_ADDR_W-1:0] == ANP_OFF_PAGE_CNT[ANP_ADDR_W-1:0]);
    addr_hit = addr_hit && (a[31:ANP_ADDR_W] == '0);
  endfunction : addr_hit

  // received word split into fields
  wire anp_page_s rx_page = anp_page_s'(page_rx_word);

  // page register: loaded only by received pages
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      page_reg <= anp_page_s'(ANP_WORD_RST);
      cnt_reg  <= 16'h0000;
    end else if (page_rx_valid) begin
      page_reg <= rx_page;
      cnt_reg  <= cnt_reg + 16'h0001;
    end
  end

  assign page_word = page_reg;

  // write path: accept both channels in either order, discard data
  wire aw_take = awvalid && awready;
  wire w_take  = wvalid && wready;
  wire aw_have = aw_got_reg || aw_take;
  wire w_have  = w_got_reg || w_take;
  wire [31:0] wr_addr = aw_got_reg ? aw_addr_reg : awaddr;
  wire wr_fire = aw_have && w_have && !bvalid;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awready     <= 1'b0;
      wready      <= 1'b0;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
      bvalid      <= 1'b0;
      bresp       <= ANP_RESP_OKAY;
    end else begin
      awready <= !aw_have && !bvalid && !awready;
      wready  <= !w_have && !bvalid && !wready;
      if (aw_take) aw_addr_reg <= awaddr;
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid     <= 1'b1;
        // read-only registers: mapped writes refused, nothing stored
        bresp      <= addr_hit(wr_addr) ? ANP_RESP_SLVERR : ANP_RESP_DECERR;
      end else begin
        aw_got_reg <= aw_have;
        w_got_reg  <= w_have;
        if (bvalid && bready) bvalid <= 1'b0;
      end
    end
  end

  // read path: one read at a time, data captured at address acceptance
  wire ar_take = arvalid && arready;
  wire [ANP_ADDR_W-1:0] rd_idx = araddr[ANP_ADDR_W-1:0];
  wire [31:0] rd_mux = (rd_idx == ANP_OFF_PAGE_WORD[ANP_ADDR_W-1:0]) ?
                       {16'h0000, page_reg} : {16'h0000, cnt_reg};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= ANP_RESP_OKAY;
    end else begin
      arready <= !arready && !rvalid && !arvalid ? 1'b1 :
                 (!arready && !rvalid && arvalid);
      if (ar_take) begin
        rvalid <= 1'b1;
        rdata  <= addr_hit(araddr) ? rd_mux : 32'h0000_0000;
        rresp  <= addr_hit(araddr) ? ANP_RESP_OKAY : ANP_RESP_DECERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // assertions
  property p_load_all;
    @(posedge clock) disable iff (!rst_b)
      page_rx_valid |=> (page_word == $past(page_rx_word));
  endproperty
  a_load_all: assert property (p_load_all) else $error("page not loaded");

  property p_hold;
    @(posedge clock) disable iff (!rst_b)
      !page_rx_valid |=> $stable(page_word);
  endproperty
  a_hold: assert property (p_hold) else $error("page changed without rx");

  // field copies: each bit follows the received word
  property p_more;
    @(posedge clock) disable iff (!rst_b)
      page_rx_valid |=> page_word[ANP_BIT_MORE] == $past(page_rx_word[ANP_BIT_MORE]);
  endproperty
  a_more: assert property (p_more) else $error("more flag wrong");

  property p_ack;
    @(posedge clock) disable iff (!rst_b)
      page_rx_valid |=> page_word[ANP_BIT_ACK] == $past(page_rx_word[ANP_BIT_ACK]);
  endproperty
  a_ack: assert property (p_ack) else $error("ack wrong");

  property p_fmt;
    @(posedge clock) disable iff (!rst_b)
      page_rx_valid |=> page_word[ANP_BIT_FMT] == $past(page_rx_word[ANP_BIT_FMT]);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format flag wrong");

  property p_comply;
    @(posedge clock) disable iff (!rst_b)
      page_rx_valid |=> page_word[ANP_BIT_COMPLY] == $past(page_rx_word[ANP_BIT_COMPLY]);
  endproperty
  a_comply: assert property (p_comply) else $error("comply flag wrong");

  property p_toggle;
    @(posedge clock) disable iff (!rst_b)
      page_rx_valid |=> page_word[ANP_BIT_TOGGLE] == $past(page_rx_word[ANP_BIT_TOGGLE]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle wrong");

  sequence s_write_done;
    wr_fire ##1 bvalid;
  endsequence
  property p_write_noeffect;
    @(posedge clock) disable iff (!rst_b)
      (wr_fire && !page_rx_valid) |=> (bresp != ANP_RESP_OKAY) && $stable(page_word);
  endproperty
  a_write_noeffect: assert property (p_write_noeffect) else $error("write had effect");

  property p_rst_null;
    @(posedge clock) disable iff (!rst_b)
      $rose(rst_b) |-> page_word[ANP_BIT_TOGGLE-1:0] == ANP_CODE_NULL;
  endproperty
  a_rst_null: assert property (p_rst_null) else $error("code not null");

  // reset image shows a formatted page
  property p_rst_fmt;
    @(posedge clock) disable iff (!rst_b)
      $rose(rst_b) |-> page_word[ANP_BIT_FMT];
  endproperty
  a_rst_fmt: assert property (p_rst_fmt) else $error("format flag not set");

  // acknowledge moves only with a received page
  property p_ack_only_rx;
    @(posedge clock) disable iff (!rst_b)
      $changed(page_word[ANP_BIT_ACK]) |-> $past(page_rx_valid);
  endproperty
  a_ack_only_rx: assert property (p_ack_only_rx) else $error("ack moved without rx");

  // comply flag moves only with a received page
  property p_comply_only_rx;
    @(posedge clock) disable iff (!rst_b)
      $changed(page_word[ANP_BIT_COMPLY]) |-> $past(page_rx_valid);
  endproperty
  a_comply_only_rx: assert property (p_comply_only_rx) else $error("comply moved");

  // every finished write is refused
  property p_write_answer;
    @(posedge clock) disable iff (!rst_b)
      s_write_done |-> (bresp != ANP_RESP_OKAY);
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answered okay");

  // a read of the page word returns the register as it stood
  sequence s_page_read;
    ar_take && (araddr == 32'(ANP_OFF_PAGE_WORD));
  endsequence
  property p_read_word;
    @(posedge clock) disable iff (!rst_b)
      s_page_read |=> (rdata == {16'h0000, $past(page_word)}) && (rresp == ANP_RESP_OKAY);
  endproperty
  a_read_word: assert property (p_read_word) else $error("page read wrong");

endmodule : anp_partner_page
`default_nettype wire

// File: verification/anp_link_partner.sv
/*
  anp_link_partner: far-side page source feeding received next pages.
  assumes: bench calls send just after a rising edge, one page at a time.
*/
`default_nettype none
module anp_link_partner (
  input  wire logic        clock,  // core clock
  output logic             valid,  // one-cycle page strobe
  output logic [15:0]      word    // received page word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog_reg = 1'b0;  // toggle of last page sent
  initial begin
    valid = 1'b0;
    word  = 16'h0000;
  end
  // strobe one page; line shows inverse word once released
  task automatic send(input logic [15:0] w);
    logic [15:0] x;
    x = {w[15:12], ~tog_reg, w[10:0]};
    tog_reg = ~tog_reg;
    valid <= 1'b1;
    word  <= x;
    @(posedge clock);
    valid <= 1'b0;
    word  <= ~x;
  endtask : send
endmodule : anp_link_partner
`default_nettype wire

// File: verification/anp_partner_page_bench.sv
/*
  anp_partner_page_bench: axi4-lite reads and writes of the page register.
  assumes: anp_pkg compiled first; partner model drives the page input.
*/
`default_nettype none
module anp_partner_page_bench import anp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rst_b = 1'b0, page_rx_valid;
  logic [15:0] page_rx_word, page_word;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, r;
  logic        tog = 1'b0;
  int          err_count = 0, checked = 0;
  logic [15:0] pg [6] = '{16'h8000, 16'h4000, 16'h0000, 16'h1000, 16'h07FF, 16'hF7FF};
  // 200 MHz clock
  always #2.5 clock = ~clock;
  anp_partner_page dut_u (.clock, .rst_b, .page_rx_valid, .page_rx_word, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .page_word);
  anp_link_partner lp_u (.clock, .valid(page_rx_valid), .word(page_rx_word));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // axi read, waits for rvalid
  task automatic rd(input logic [31:0] a);
    @(posedge clock);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // axi write, address and data together
  task automatic wr(input logic [31:0] a);
    @(posedge clock);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata  <= 32'hFFFF_FFFF;
    wstrb  <= 4'hF;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    chk(32'(page_word), 32'(ANP_WORD_RST));
    rd(32'(ANP_OFF_PAGE_WORD));
    chk(d, 32'h0000_2001);
    chk(32'(r), 32'(ANP_RESP_OKAY));
    foreach (pg[i]) begin
      tog = ~tog;
      lp_u.send(pg[i]);
      rd(32'h8);
      chk(d, {16'h0000, pg[i][15:12], tog, pg[i][10:0]});
      chk(32'(r), 32'(ANP_RESP_OKAY));
      chk(32'(page_word), {16'h0000, pg[i][15:12], tog, pg[i][10:0]});
    end
    rd(32'(ANP_OFF_PAGE_CNT));
    chk(d, 32'h6);
    wr(32'h8);
    chk(32'(r), 32'(ANP_RESP_SLVERR));
    rd(32'h8);
    chk(d, 32'h0000_F7FF);
    wr(32'h10);
    chk(32'(r), 32'(ANP_RESP_DECERR));
    rd(32'h10);
    chk({d[29:0], r}, 32'(ANP_RESP_DECERR));
    chk(d, 32'h0000_0000);
    print_verdict();
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge clock);
    err_count++;
    print_verdict();
  end
endmodule : anp_partner_page_bench
`default_nettype wire
